// ### hdl/synth_out_pkg.sv
// Shared constants and types for the voice envelope and stereo serial output block
package synth_out_pkg;
	localparam int unsigned SYS_CLK_HZ = 50_000_000;
	localparam int unsigned FRAME_HZ = 50_000;
	localparam int unsigned FRAME_CYCLES = SYS_CLK_HZ / FRAME_HZ;
	localparam int unsigned SLOTS_PER_FRAME = 32;
	localparam int unsigned HALF_BIT_CYCLES = FRAME_CYCLES / (SLOTS_PER_FRAME * 2);
	localparam int unsigned NUM_VOICES = 16;
	localparam int unsigned VOICE_W = 4;
	localparam int unsigned ATTEN_W = 10;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned MEM_AW = 12;
	localparam int unsigned LOOP_W = 15;
	localparam int unsigned FRAME_CNT_W = 10;
	localparam int unsigned HALF_CNT_W = 4;
	localparam int unsigned BIT_IDX_W = 5;

	localparam logic [7:0] END_CODE = 8'h80;
	localparam logic [9:0] ATTEN_LOUDEST = 10'h000;
	localparam logic [9:0] ATTEN_SILENT = 10'h3ff;
	localparam logic [1:0] ENV_LOW3 = 2'h0;
	localparam logic [1:0] ENV_LOW2 = 2'h1;
	localparam logic [1:0] ENV_LOW1 = 2'h2;
	localparam logic [1:0] ENV_NONE = 2'h3;

	localparam logic [5:0] OFS_VOICE = 6'h00;
	localparam logic [5:0] OFS_ENV = 6'h04;
	localparam logic [5:0] OFS_LEFT = 6'h08;
	localparam logic [5:0] OFS_RIGHT = 6'h0c;
	localparam logic [5:0] OFS_START = 6'h10;
	localparam logic [5:0] OFS_LOOP = 6'h14;
	localparam logic [5:0] OFS_MEM_ADDR = 6'h18;
	localparam logic [5:0] OFS_MEM_DATA = 6'h1c;
	localparam logic [5:0] OFS_STATE = 6'h20;

	localparam int unsigned VOICE_UPD_ONLY_BIT = 4;
	localparam int unsigned ENV_AR_BIT = 2;
	localparam int unsigned LEFT_SLOT_LAST = 15;
	localparam int unsigned RIGHT_SLOT_LAST = 31;

	typedef struct packed {
		logic [WORD_W-1:0] right;
		logic [WORD_W-1:0] left;
	} stereo_word_t;

	typedef struct packed {
		logic attach;
		logic [1:0] env_type;
		logic [ATTEN_W-1:0] left;
		logic [ATTEN_W-1:0] right;
	} voice_level_t;
endpackage : synth_out_pkg

// ### hdl/stereo_serializer.sv
// Serial stereo sender: bit clock, word clock and LSB-first data
`timescale 1ns/1ns
module stereo_serializer import synth_out_pkg::*; (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic load_in,
	input stereo_word_t word_in,
	output logic bit_clk_out,
	output logic word_clk_out,
	output logic data_out
);
	stereo_word_t word_q;
	logic [HALF_CNT_W-1:0] half_q;
	logic [BIT_IDX_W-1:0] idx_q;
	logic run_q;
	logic bclk_q;
	logic wclk_q;
	logic sdata_q;

	wire half_end = run_q && (half_q == HALF_CNT_W'(HALF_BIT_CYCLES - 1));
	wire fall_now = half_end && bclk_q;
	wire last_bit = (idx_q == BIT_IDX_W'(RIGHT_SLOT_LAST));
	wire [BIT_IDX_W-1:0] idx_nx = idx_q + BIT_IDX_W'(1);
	wire [2*WORD_W-1:0] flat = {word_q.right, word_q.left};

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			word_q <= '0;
			half_q <= '0;
			idx_q <= '0;
			run_q <= 1'b0;
			bclk_q <= 1'b0;
			wclk_q <= 1'b0;
			sdata_q <= 1'b0;
		end else if (load_in) begin
			word_q <= word_in;
			half_q <= '0;
			idx_q <= '0;
			run_q <= 1'b1;
			bclk_q <= 1'b0;
			wclk_q <= 1'b0;
			sdata_q <= word_in.left[0];
		end else if (run_q) begin
			half_q <= half_end ? '0 : half_q + HALF_CNT_W'(1);
			if (half_end) begin
				bclk_q <= ~bclk_q;
			end
			if (fall_now) begin
				// Data and word clock move only with the falling edge or a load
				if (last_bit) begin
					run_q <= 1'b0;
				end else begin
					idx_q <= idx_nx;
					sdata_q <= flat[idx_nx];
					wclk_q <= (idx_nx > BIT_IDX_W'(LEFT_SLOT_LAST));
				end
			end
		end
	end

	assign bit_clk_out = bclk_q;
	assign word_clk_out = wclk_q;
	assign data_out = sdata_q;

	a_wclk_side_select: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		run_q |-> (wclk_q == (idx_q > BIT_IDX_W'(LEFT_SLOT_LAST))))
		else $error("word clock does not match channel side");
	a_data_on_fall: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		($changed(sdata_q) || $changed(wclk_q)) |-> ($fell(bclk_q) || $past(load_in)))
		else $error("serial data changed away from a falling bit clock");
	a_bclk_half_period: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		$rose(bclk_q) |-> ##15 $fell(bclk_q))
		else $error("bit clock high phase has wrong length");
	a_lsb_goes_first: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		load_in |=> (sdata_q == $past(word_in.left[0])) && !wclk_q)
		else $error("first serial bit is not the left LSB");
	c_full_frame_sent: cover property (@(posedge clk_sys_in) disable iff (reset_in)
		$fell(run_q));
endmodule : stereo_serializer

// ### hdl/voice_out_stage.sv
// Voice envelope, PCM mixer and register slave feeding the stereo serializer
`timescale 1ns/1ns
module voice_out_stage import synth_out_pkg::*; (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic [5:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	output logic serial_bit_clk_out,
	output logic word_clk_out,
	output logic serial_data_out
);
	typedef enum logic [2:0] {
		S_IDLE = 3'b001,
		S_READ = 3'b010,
		S_MIX = 3'b100
	} eng_state_t;

	function automatic logic [ATTEN_W-1:0] env_step(input logic [ATTEN_W-1:0] code,
			input logic [1:0] typ, input logic attach);
		logic [2:0] mask;
		logic [2:0] low;
		logic [2:0] nxt;
		mask = 3'h0;
		case (typ)
			ENV_LOW3: mask = 3'h7;
			ENV_LOW2: mask = 3'h3;
			ENV_LOW1: mask = 3'h1;
			default: mask = 3'h0;
		endcase
		low = code[2:0] & mask;
		nxt = low;
		if (attach && low != 3'h0) begin
			nxt = low - 3'h1;
		end else if (!attach && low != mask) begin
			nxt = low + 3'h1;
		end
		env_step = {code[ATTEN_W-1:3], (code[2:0] & ~mask) | (nxt & mask)};
	endfunction : env_step

	function automatic logic [WORD_W-1:0] sat16(input logic signed [23:0] acc);
		logic signed [23:0] sh;
		sh = acc >>> 2;
		if (sh > 24'sh007fff) begin
			sat16 = 16'h7fff;
		end else if (sh < -24'sh008000) begin
			sat16 = 16'h8000;
		end else begin
			sat16 = sh[WORD_W-1:0];
		end
	endfunction : sat16

	// Bus slave: one wait cycle per access
	logic ack_q;
	logic [31:0] rdata_q;
	voice_level_t stage_q;
	logic [MEM_AW-1:0] stage_start_q;
	logic [LOOP_W-1:0] stage_loop_q;
	logic [MEM_AW-1:0] mem_addr_q;
	logic [VOICE_W-1:0] sel_q;

	wire req = avs_read_in || avs_write_in;
	wire wr_acc = avs_write_in && ack_q;
	wire wr_voice = wr_acc && (avs_address_in == OFS_VOICE);
	wire wr_mem = wr_acc && (avs_address_in == OFS_MEM_DATA);
	wire [VOICE_W-1:0] wr_sel = avs_writedata_in[VOICE_W-1:0];
	wire wr_upd_only = avs_writedata_in[VOICE_UPD_ONLY_BIT];

	// Voice state
	logic [ATTEN_W-1:0] vatt_l_q [NUM_VOICES];
	logic [ATTEN_W-1:0] vatt_r_q [NUM_VOICES];
	logic [2:0] venv_q [NUM_VOICES];
	logic [LOOP_W-1:0] vloop_q [NUM_VOICES];
	logic [MEM_AW-1:0] vptr_q [NUM_VOICES];
	logic [NUM_VOICES-1:0] vact_q;

	// Sample memory, loaded by software
	logic [7:0] smp_mem [2**MEM_AW];
	logic [7:0] smp_q;

	// Frame timing and mixer
	logic [FRAME_CNT_W-1:0] frame_cnt_q;
	eng_state_t st_q;
	logic [VOICE_W-1:0] idx_q;
	logic signed [23:0] acc_l_q;
	logic signed [23:0] acc_r_q;
	stereo_word_t mix_q;

	wire frame_tick = (frame_cnt_q == FRAME_CNT_W'(FRAME_CYCLES - 1));
	wire in_mix = (st_q == S_MIX);
	wire cur_act = vact_q[idx_q];
	wire [ATTEN_W-1:0] cur_l = vatt_l_q[idx_q];
	wire [ATTEN_W-1:0] cur_r = vatt_r_q[idx_q];
	wire [2:0] cur_env = venv_q[idx_q];
	wire is_end = (smp_q == END_CODE);
	wire plays = cur_act && !is_end;
	wire [ATTEN_W-1:0] env_l_nx = env_step(cur_l, cur_env[1:0], cur_env[ENV_AR_BIT]);
	wire [ATTEN_W-1:0] env_r_nx = env_step(cur_r, cur_env[1:0], cur_env[ENV_AR_BIT]);
	wire silent = (cur_l == ATTEN_SILENT) && (cur_r == ATTEN_SILENT);
	wire do_loop = (vloop_q[idx_q] != '0) && !silent;
	wire [MEM_AW-1:0] loop_ptr = vptr_q[idx_q] + vloop_q[idx_q][MEM_AW-1:0];
	wire [ATTEN_W-1:0] gain_l = ATTEN_SILENT - cur_l;
	wire [ATTEN_W-1:0] gain_r = ATTEN_SILENT - cur_r;
	wire signed [18:0] prod_l = $signed(smp_q) * $signed({1'b0, gain_l});
	wire signed [18:0] prod_r = $signed(smp_q) * $signed({1'b0, gain_r});
	wire signed [23:0] add_l = plays ? 24'(prod_l) : 24'sh0;
	wire signed [23:0] add_r = plays ? 24'(prod_r) : 24'sh0;
	wire last_voice = (idx_q == VOICE_W'(NUM_VOICES - 1));

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req && !ack_q;
		end
	end
	assign avs_waitrequest_out = req && !ack_q;

	wire [31:0] rd_mux =
		(avs_address_in == OFS_VOICE) ? {16'h0, vact_q} :
		(avs_address_in == OFS_ENV) ? {29'h0, stage_q.attach, stage_q.env_type} :
		(avs_address_in == OFS_LEFT) ? {22'h0, stage_q.left} :
		(avs_address_in == OFS_RIGHT) ? {22'h0, stage_q.right} :
		(avs_address_in == OFS_START) ? {20'h0, stage_start_q} :
		(avs_address_in == OFS_LOOP) ? {17'h0, stage_loop_q} :
		(avs_address_in == OFS_MEM_ADDR) ? {20'h0, mem_addr_q} :
		(avs_address_in == OFS_STATE) ? {6'h0, vatt_r_q[sel_q], 6'h0, vatt_l_q[sel_q]} :
		32'h0;

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			rdata_q <= 32'h0;
		end else if (avs_read_in && !ack_q) begin
			rdata_q <= rd_mux;
		end
	end
	assign avs_readdata_out = rdata_q;

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			stage_q <= '{attach: 1'b0, env_type: ENV_NONE, left: ATTEN_LOUDEST,
				right: ATTEN_LOUDEST};
			stage_start_q <= '0;
			stage_loop_q <= '0;
			mem_addr_q <= '0;
			sel_q <= '0;
		end else if (wr_acc) begin
			case (avs_address_in)
				OFS_VOICE: sel_q <= wr_sel;
				OFS_ENV: begin
					stage_q.attach <= avs_writedata_in[ENV_AR_BIT];
					stage_q.env_type <= avs_writedata_in[1:0];
				end
				OFS_LEFT: stage_q.left <= avs_writedata_in[ATTEN_W-1:0];
				OFS_RIGHT: stage_q.right <= avs_writedata_in[ATTEN_W-1:0];
				OFS_START: stage_start_q <= avs_writedata_in[MEM_AW-1:0];
				OFS_LOOP: stage_loop_q <= avs_writedata_in[LOOP_W-1:0];
				OFS_MEM_ADDR: mem_addr_q <= avs_writedata_in[MEM_AW-1:0];
				OFS_MEM_DATA: mem_addr_q <= mem_addr_q + MEM_AW'(1);
				default: sel_q <= sel_q;
			endcase
		end
	end

	// Memory kept without reset so it maps to block RAM
	always_ff @(posedge clk_sys_in) begin
		if (wr_mem) begin
			smp_mem[mem_addr_q] <= avs_writedata_in[7:0];
		end
		smp_q <= smp_mem[vptr_q[idx_q]];
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			frame_cnt_q <= '0;
		end else begin
			frame_cnt_q <= frame_tick ? '0 : frame_cnt_q + FRAME_CNT_W'(1);
		end
	end

	// Engine walks all voices once per frame; a voice write in the same cycle wins
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			for (int v = 0; v < NUM_VOICES; v++) begin
				vatt_l_q[v] <= ATTEN_SILENT;
				vatt_r_q[v] <= ATTEN_SILENT;
				venv_q[v] <= {1'b0, ENV_NONE};
				vloop_q[v] <= '0;
				vptr_q[v] <= '0;
			end
			vact_q <= '0;
		end else begin
			if (in_mix && cur_act) begin
				vatt_l_q[idx_q] <= env_l_nx;
				vatt_r_q[idx_q] <= env_r_nx;
				if (!is_end) begin
					vptr_q[idx_q] <= vptr_q[idx_q] + MEM_AW'(1);
				end else if (do_loop) begin
					vptr_q[idx_q] <= loop_ptr;
				end else begin
					vact_q[idx_q] <= 1'b0;
				end
			end
			if (wr_voice) begin
				vatt_l_q[wr_sel] <= stage_q.left;
				vatt_r_q[wr_sel] <= stage_q.right;
				venv_q[wr_sel] <= {stage_q.attach, stage_q.env_type};
				if (!wr_upd_only) begin
					vloop_q[wr_sel] <= stage_loop_q;
					vptr_q[wr_sel] <= stage_start_q;
					vact_q[wr_sel] <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			st_q <= S_IDLE;
			idx_q <= '0;
			acc_l_q <= '0;
			acc_r_q <= '0;
			mix_q <= '0;
		end else begin
			case (st_q)
				S_IDLE: if (frame_tick) begin
					idx_q <= '0;
					acc_l_q <= '0;
					acc_r_q <= '0;
					st_q <= S_READ;
				end
				S_READ: st_q <= S_MIX;
				S_MIX: begin
					acc_l_q <= acc_l_q + add_l;
					acc_r_q <= acc_r_q + add_r;
					if (last_voice) begin
						mix_q.left <= sat16(acc_l_q + add_l);
						mix_q.right <= sat16(acc_r_q + add_r);
						st_q <= S_IDLE;
					end else begin
						idx_q <= idx_q + VOICE_W'(1);
						st_q <= S_READ;
					end
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	stereo_serializer u_ser (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.load_in(frame_tick),
		.word_in(mix_q),
		.bit_clk_out(serial_bit_clk_out),
		.word_clk_out(word_clk_out),
		.data_out(serial_data_out)
	);

	// Helper for frame period check
	logic [FRAME_CNT_W:0] gap_q;
	logic seen_q;
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			gap_q <= '0;
			seen_q <= 1'b0;
		end else begin
			gap_q <= frame_tick ? '0 : gap_q + (FRAME_CNT_W + 1)'(1);
			seen_q <= seen_q || frame_tick;
		end
	end

	a_frame_period: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(frame_tick && seen_q) |-> (gap_q == (FRAME_CNT_W + 1)'(FRAME_CYCLES - 1)))
		else $error("stereo frame period is wrong");
	a_end_code_muted: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(in_mix && is_end) |-> (add_l == 24'sh0) && (add_r == 24'sh0))
		else $error("end code was mixed as audio");
	a_silent_code_zero: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		in_mix |-> ((cur_l != ATTEN_SILENT) || (add_l == 24'sh0))
			&& ((cur_r != ATTEN_SILENT) || (add_r == 24'sh0)))
		else $error("quietest code still produced output");
	a_attach_steps_down: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(in_mix && cur_env == 3'b100 && cur_l[2:0] != 3'h0)
		|-> (env_l_nx == cur_l - ATTEN_W'(1)))
		else $error("attach step did not lower the low bits by one");
	a_release_steps_up: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(in_mix && cur_env == 3'b001 && cur_r[1:0] != 2'h3)
		|-> (env_r_nx == cur_r + ATTEN_W'(1)))
		else $error("release step did not raise the low bits by one");
	a_no_change_mode: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(in_mix && cur_env[1:0] == ENV_NONE) |-> (env_l_nx == cur_l) && (env_r_nx == cur_r))
		else $error("no-change envelope altered a volume code");
	a_select_starts: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(wr_voice && !wr_upd_only) |=> vact_q[$past(wr_sel)])
		else $error("voice select write did not start the voice");
	c_end_reached: cover property (@(posedge clk_sys_in) disable iff (reset_in)
		in_mix && cur_act && is_end && !do_loop);
	c_loop_taken: cover property (@(posedge clk_sys_in) disable iff (reset_in)
		in_mix && cur_act && is_end && do_loop);
	c_vibrato_flip: cover property (@(posedge clk_sys_in) disable iff (reset_in)
		wr_voice && wr_upd_only);
endmodule : voice_out_stage

// ### verification/dac_receiver_model.sv
// Stereo serial DAC receiver model: decodes words, counts frames and link faults
`timescale 1ns/1ns
module dac_receiver_model (
	input wire logic clk_sys_in,
	input wire logic bit_clk_in,
	input wire logic word_clk_in,
	input wire logic data_in,
	output logic [15:0] left_out,
	output logic [15:0] right_out,
	output int frame_cnt_out,
	output int period_out,
	output int fault_cnt_out
);
	logic bclk_q = 1'b0;
	logic wclk_q = 1'b1;
	logic data_q = 1'b0;
	logic [31:0] shift_q = '0;
	int bits_q = 0;
	int since_q = 0;
	int idx;
	wire rise = bit_clk_in & ~bclk_q;
	wire frame_start = rise & ~word_clk_in & wclk_q;
	wire [31:0] shift_d = {data_in, shift_q[31:1]};
	wire bad_data = data_in !== data_q;
	wire bad_word = word_clk_in !== (idx >= 16);
	assign idx = frame_start ? 0 : bits_q;
	initial begin
		left_out = '0;
		right_out = '0;
		frame_cnt_out = 0;
		period_out = 0;
		fault_cnt_out = 0;
	end
	// Data must already be settled when the bit clock rises
	always @(posedge clk_sys_in) begin
		bclk_q <= bit_clk_in;
		data_q <= data_in;
		since_q <= frame_start ? 0 : since_q + 1;
		if (rise) begin
			wclk_q <= word_clk_in;
			shift_q <= shift_d;
			bits_q <= idx + 1;
			fault_cnt_out <= fault_cnt_out + int'(bad_data) + int'(bad_word) + int'(idx > 31);
			if (frame_start)
				period_out <= since_q + 1;
			if (idx == 31) begin
				left_out <= shift_d[15:0];
				right_out <= shift_d[31:16];
				frame_cnt_out <= frame_cnt_out + 1;
			end
		end
	end
endmodule : dac_receiver_model

// ### verification/voice_out_stage_tb.sv
// Self-checking bench for the voice output stage and its serial link
`timescale 1ns/1ns
module voice_out_stage_tb;
	import synth_out_pkg::*;
	logic clk_sys_in = 1'b0;
	logic reset_in = 1'b1;
	logic [5:0] addr = '0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = '0;
	logic [31:0] rdata;
	logic waitreq;
	logic bclk;
	logic wclk;
	logic sdata;
	logic [15:0] left_w;
	logic [15:0] right_w;
	int frames;
	int period;
	int faults;
	int err_total = 0;
	int check_count = 0;
	always #10 clk_sys_in = ~clk_sys_in;
	voice_out_stage voice_out_stage_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
		.avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wdata), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
		.serial_bit_clk_out(bclk), .word_clk_out(wclk), .serial_data_out(sdata));
	dac_receiver_model dac_receiver_model_i (.clk_sys_in(clk_sys_in), .bit_clk_in(bclk),
		.word_clk_in(wclk), .data_in(sdata), .left_out(left_w), .right_out(right_w),
		.frame_cnt_out(frames), .period_out(period), .fault_cnt_out(faults));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check
	task automatic conclude();
		$display("checks=%0d errors=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude
	// Held until waitrequest is sampled low at a rising edge, released right after it
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_sys_in);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= ~w;
		@(posedge clk_sys_in);
		while (waitreq !== 1'b0)
			@(posedge clk_sys_in);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus
	task automatic wr32(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr32
	task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, '0, q);
		check(q, e);
	endtask : rd_chk
	task automatic wait_frames(input int n);
		int t;
		t = frames + n;
		while (frames < t)
			@(posedge clk_sys_in);
	endtask : wait_frames
	task automatic t_reset();
		rd_chk(OFS_STATE, 32'h03ff03ff);
		rd_chk(OFS_VOICE, 32'h0);
		wr32(6'h3c, 32'hffffffff);
		rd_chk(6'h3c, 32'h0);
	endtask : t_reset
	task automatic t_regs();
		wr32(OFS_LEFT, 32'h2a5);
		wr32(OFS_RIGHT, 32'h15a);
		rd_chk(OFS_LEFT, 32'h2a5);
		rd_chk(OFS_RIGHT, 32'h15a);
		wr32(OFS_ENV, 32'h6);
		rd_chk(OFS_ENV, 32'h6);
	endtask : t_regs
	task automatic t_idle();
		wait_frames(3);
		check(32'(left_w), 32'h0);
		check(32'(right_w), 32'h0);
		check(period, FRAME_CYCLES);
		check(faults, 0);
	endtask : t_idle
	// Every section closes with the end code
	task automatic t_load();
		logic [7:0] b;
		wr32(OFS_MEM_ADDR, 32'h0);
		for (int i = 0; i < 36; i++) begin
			b = (i < 6) ? 8'h40 : (i >= 16 && i < 22) ? 8'h20 : 8'h00;
			if (i == 6 || i == 22 || i == 35)
				b = END_CODE;
			wr32(OFS_MEM_DATA, 32'(b));
		end
	endtask : t_load
	task automatic t_play();
		int hits;
		int neg;
		hits = 0;
		neg = 0;
		wr32(OFS_ENV, 32'(ENV_NONE));
		wr32(OFS_LOOP, 32'h0);
		wr32(OFS_LEFT, 32'h0);
		wr32(OFS_RIGHT, 32'(ATTEN_SILENT));
		wr32(OFS_START, 32'h0);
		wr32(OFS_VOICE, 32'h0);
		wr32(OFS_RIGHT, 32'h0);
		wr32(OFS_START, 32'h10);
		wr32(OFS_VOICE, 32'h1);
		rd_chk(OFS_VOICE, 32'h3);
		repeat (12) begin
			wait_frames(1);
			if (left_w === 16'h5fe8 && right_w === 16'h1ff8)
				hits++;
			if (left_w[15] | right_w[15])
				neg++;
		end
		check(32'(hits != 0), 32'h1);
		check(neg, 0);
		rd_chk(OFS_VOICE, 32'h0);
	endtask : t_play
	// Attach, release and no-change envelope steps on one looping voice
	task automatic t_env();
		logic [31:0] st_in [6] = '{32'h000703c5, 32'h02f10100, 32'h00010007,
			32'h03fe0010, 32'h00aa0155, 32'h00f00008};
		logic [31:0] st_ex [6] = '{32'h000003c0, 32'h02f30103, 32'h00000006,
			32'h03ff0011, 32'h00aa0155, 32'h00f7000f};
		logic [2:0] env [6] = '{3'h4, 3'h1, 3'h6, 3'h2, 3'h3, 3'h0};
		wr32(OFS_START, 32'h20);
		wr32(OFS_LOOP, 32'h7ffd);
		for (int k = 0; k < 6; k++) begin
			wr32(OFS_LEFT, 32'(st_in[k][9:0]));
			wr32(OFS_RIGHT, 32'(st_in[k][25:16]));
			wr32(OFS_ENV, 32'(env[k]));
			wr32(OFS_VOICE, (k == 0) ? 32'h2 : 32'h12);
			wait_frames(8);
			rd_chk(OFS_STATE, st_ex[k]);
		end
		rd_chk(OFS_VOICE, 32'h4);
		// Silent on both sides: the loop must give up at the next end code
		wr32(OFS_LEFT, 32'(ATTEN_SILENT));
		wr32(OFS_RIGHT, 32'(ATTEN_SILENT));
		wr32(OFS_ENV, 32'(ENV_NONE));
		wr32(OFS_VOICE, 32'h12);
		wait_frames(8);
		rd_chk(OFS_VOICE, 32'h0);
	endtask : t_env
	initial begin
		repeat (6) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		t_reset();
		t_regs();
		t_idle();
		t_load();
		t_play();
		t_env();
		conclude();
	end
	// Whole run needs about 71k cycles
	initial begin
		#1_900_000;
		err_total++;
		conclude();
	end
endmodule : voice_out_stage_tb
